// ### logic/cti_consts.svh
// Offsets, writable masks, field positions and reset values of the CAN timing block.
`ifndef CTI_CONSTS_SVH
`define CTI_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets in data space
// -----------------------------------------------------------------
`define CTI_OFS_TIMING_ONE   12'hf70
`define CTI_OFS_TIMING_TWO   12'hf71
`define CTI_OFS_TIMING_THREE 12'hf72
`define CTI_OFS_PIN_CTRL     12'hf73
`define CTI_OFS_FLAGS        12'hfa4
`define CTI_OFS_ENABLES      12'hfa3
`define CTI_OFS_PRIORITIES   12'hfa5

// -----------------------------------------------------------------
// Writable masks, reset values and field positions
// -----------------------------------------------------------------
`define CTI_MASK_TIMING_THREE 8'h47
`define CTI_MASK_PIN_CTRL     8'hf0
`define CTI_RESET_VALUE       8'h00
`define CTI_BIT_WAKE_FILT     6
`define CTI_BIT_FREE_SEL      7
`define CTI_BIT_TX1_SRC       7
`define CTI_BIT_TX1_EN        6
`define CTI_BIT_DRIVE_HI      5
`define CTI_BIT_CAPTURE       4
`define CTI_BIT_WAKE_FLAG     6
`define CTI_BIT_ERR_FLAG      5
`define CTI_BIT_INV_FLAG      7
`define CTI_DISABLED_GATE     8'h40

`endif

// ### logic/cti_pkg.sv
// Types shared by the CAN timing, pin control and event block.
package cti_pkg;

   // Drive of one transmit pin: level and active-low output enable.
   typedef struct packed {
      logic out;
      logic oe_n;
   } cti_pin_t;

   // Event strobes from the protocol engine, one cycle each.
   typedef struct packed {
      logic invalid_msg;
      logic tx_two_done;
      logic tx_one_done;
      logic tx_zero_done;
      logic rx_one_full;
      logic rx_zero_full;
   } cti_evt_t;

endpackage

// ### logic/cti_top.sv
// Timing, pin control and interrupt event logic of the CAN controller.
`timescale 1ns/1ps
`include "cti_consts.svh"

module cti_top
   import cti_pkg::*;
#(
   parameter int ERR_SRCS = 4,
   parameter int FILT_LEN = 4,
   parameter logic [3:0] IPT_QUANTA = 4'h2
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst_n,
   input  wire logic [11:0]         i_addr,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   input  wire logic [7:0]          i_wdata,
   output logic      [7:0]          o_rdata,
   input  wire logic                i_rx_pin,
   input  wire logic                i_tx_data,
   input  wire logic                i_can_clk,
   input  wire logic                i_port_tx1_out,
   input  wire logic                i_port_tx1_oe_n,
   input  wire logic                i_mod_disabled,
   input  wire logic                i_rx_msg_evt,
   input  wire cti_evt_t            i_evt,
   input  wire logic [ERR_SRCS-1:0] i_err_src,
   output cti_pin_t                 o_tx0,
   output cti_pin_t                 o_tx1,
   output logic                     o_capture_evt,
   output logic                     o_wake_evt,
   output logic                     o_quantum_tick,
   output logic [3:0]               o_phase_two_len,
   output logic                     o_irq_high,
   output logic                     o_irq_low
);

   // -----------------------------------------------------------------
   // Registers and internal signals
   // -----------------------------------------------------------------
   logic [7:0] timing_one_q;
   logic [7:0] timing_two_q;
   logic [7:0] timing_three_q;
   logic [7:0] pin_ctrl_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] enables_q;
   logic [7:0] prio_q;
   logic [7:0] rdata_q;
   logic [6:0] quantum_cnt_q;
   logic       rx_s1_q;
   logic       rx_s2_q;
   logic [2:0] filt_cnt_q;
   logic       filt_q;
   logic       wake_line_q;

   // -----------------------------------------------------------------
   // Address decode and read selection
   // -----------------------------------------------------------------
   wire sel_one   = (i_addr == `CTI_OFS_TIMING_ONE);
   wire sel_two   = (i_addr == `CTI_OFS_TIMING_TWO);
   wire sel_three = (i_addr == `CTI_OFS_TIMING_THREE);
   wire sel_pin   = (i_addr == `CTI_OFS_PIN_CTRL);
   wire sel_flags = (i_addr == `CTI_OFS_FLAGS);
   wire sel_en    = (i_addr == `CTI_OFS_ENABLES);
   wire sel_prio  = (i_addr == `CTI_OFS_PRIORITIES);

   // Unmapped addresses read as zero.
   wire [7:0] rd_mux =
      sel_one   ? timing_one_q   :
      sel_two   ? timing_two_q   :
      sel_three ? timing_three_q :
      sel_pin   ? pin_ctrl_q     :
      sel_flags ? flags_q        :
      sel_en    ? enables_q      :
      sel_prio  ? prio_q         : 8'h00;

   // -----------------------------------------------------------------
   // Configuration field decode
   // -----------------------------------------------------------------
   wire [5:0] quantum_prescaler     = timing_one_q[5:0];
   wire       phase_two_free_select = timing_two_q[`CTI_BIT_FREE_SEL];
   wire [2:0] phase_one_code        = timing_two_q[5:3];
   wire       wake_line_filter_sel  = timing_three_q[`CTI_BIT_WAKE_FILT];
   wire [2:0] phase_two_length      = timing_three_q[2:0];
   wire       second_tx_pin_source  = pin_ctrl_q[`CTI_BIT_TX1_SRC];
   wire       second_tx_pin_enable  = pin_ctrl_q[`CTI_BIT_TX1_EN];
   wire       recessive_drive_high  = pin_ctrl_q[`CTI_BIT_DRIVE_HI];
   wire       receive_capture_enable = pin_ctrl_q[`CTI_BIT_CAPTURE];

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   // Reserved bits are masked off so they never store a one.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timing_one_q   <= `CTI_RESET_VALUE;
         timing_two_q   <= `CTI_RESET_VALUE;
         timing_three_q <= `CTI_RESET_VALUE;
         pin_ctrl_q     <= `CTI_RESET_VALUE;
         enables_q      <= `CTI_RESET_VALUE;
         prio_q         <= `CTI_RESET_VALUE;
      end else if (i_wr) begin
         if (sel_one) timing_one_q <= i_wdata;
         if (sel_two) timing_two_q <= i_wdata;
         if (sel_three) timing_three_q <= i_wdata & `CTI_MASK_TIMING_THREE;
         if (sel_pin) pin_ctrl_q <= i_wdata & `CTI_MASK_PIN_CTRL;
         if (sel_en) enables_q <= i_wdata;
         if (sel_prio) prio_q <= i_wdata;
      end
   end

   // Read data is registered and appears the cycle after the strobe.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         rdata_q <= rd_mux;
      end
   end
   assign o_rdata = rdata_q;

   // -----------------------------------------------------------------
   // Time quantum generator
   // -----------------------------------------------------------------
   // One tick every 2 x (prescaler + 1) system clocks.
   wire [6:0] quantum_last = {quantum_prescaler, 1'b1};
   wire       quantum_wrap = (quantum_cnt_q >= quantum_last);
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         quantum_cnt_q <= 7'h00;
      end else begin
         quantum_cnt_q <= quantum_wrap ? 7'h00 : quantum_cnt_q + 7'h01;
      end
   end
   assign o_quantum_tick = quantum_wrap;

   // -----------------------------------------------------------------
   // Phase segment two length in quanta
   // -----------------------------------------------------------------
   wire [3:0] seg_one_len = {1'b0, phase_one_code} + 4'h1;
   wire [3:0] seg_two_len = {1'b0, phase_two_length} + 4'h1;
   wire [3:0] auto_len    = (seg_one_len > IPT_QUANTA) ? seg_one_len : IPT_QUANTA;
   assign o_phase_two_len = phase_two_free_select ? seg_two_len : auto_len;

   // -----------------------------------------------------------------
   // Receive line synchroniser, line filter and wake detection
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         rx_s1_q <= i_rx_pin;
         rx_s2_q <= rx_s1_q;
      end
   end

   // The filter only follows the line after FILT_LEN equal samples,
   // so short glitches do not wake the module.
   wire filt_hold = (rx_s2_q == filt_q);
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         filt_cnt_q <= 3'h0;
         filt_q     <= 1'b1;
      end else if (filt_hold) begin
         filt_cnt_q <= 3'h0;
      end else if (filt_cnt_q == 3'(FILT_LEN - 1)) begin
         filt_cnt_q <= 3'h0;
         filt_q     <= rx_s2_q;
      end else begin
         filt_cnt_q <= filt_cnt_q + 3'h1;
      end
   end

   // Wake event is a recessive-to-dominant change on the chosen line.
   wire wake_line = wake_line_filter_sel ? filt_q : rx_s2_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wake_line_q <= 1'b1;
      end else begin
         wake_line_q <= wake_line;
      end
   end
   assign o_wake_evt = wake_line_q & ~wake_line;

   // -----------------------------------------------------------------
   // Transmit pin drive
   // -----------------------------------------------------------------
   // Data is dominant low; a recessive bit floats unless drive high is set.
   wire recessive = i_tx_data;
   wire float_rec = recessive & ~recessive_drive_high;
   assign o_tx0.out  = i_tx_data;
   assign o_tx0.oe_n = float_rec;

   // Second pin: clock is always driven, inverted data follows drive style.
   wire tx1_mod_out  = second_tx_pin_source ? i_can_clk : ~i_tx_data;
   wire tx1_mod_oe_n = second_tx_pin_source ? 1'b0 : float_rec;
   assign o_tx1.out  = second_tx_pin_enable ? tx1_mod_out : i_port_tx1_out;
   assign o_tx1.oe_n = second_tx_pin_enable ? tx1_mod_oe_n : i_port_tx1_oe_n;

   // Capture events pass only while capture is enabled.
   assign o_capture_evt = receive_capture_enable & i_rx_msg_evt;

   // -----------------------------------------------------------------
   // Event flags
   // -----------------------------------------------------------------
   wire       err_any = |i_err_src;
   wire [7:0] set_vec = {i_evt.invalid_msg, o_wake_evt, err_any,
                         i_evt.tx_two_done, i_evt.tx_one_done,
                         i_evt.tx_zero_done, i_evt.rx_one_full,
                         i_evt.rx_zero_full};

   // A hardware set in the cycle of a software write wins over the clear.
   always_comb begin
      flags_d = (i_wr && sel_flags) ? i_wdata : flags_q;
      flags_d = flags_d | set_vec;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_q <= `CTI_RESET_VALUE;
      end else begin
         flags_q <= flags_d;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt routing
   // -----------------------------------------------------------------
   wire [7:0] gate    = i_mod_disabled ? `CTI_DISABLED_GATE : 8'hff;
   wire [7:0] pending = flags_q & enables_q & gate;
   assign o_irq_high = |(pending & prio_q);
   assign o_irq_low  = |(pending & ~prio_q);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   property p_wake_filter;
      wake_line_filter_sel && $stable(wake_line_filter_sel) |-> o_wake_evt == ($past(filt_q) && !filt_q);
   endproperty
   a_wake_filter: assert property (p_wake_filter) else $error("wake not from filter");

   property p_free_len;
      phase_two_free_select |-> o_phase_two_len == {1'b0, timing_three_q[2:0]} + 4'h1;
   endproperty
   a_free_len: assert property (p_free_len) else $error("free length wrong");

   property p_auto_len;
      !phase_two_free_select |-> o_phase_two_len >= IPT_QUANTA && o_phase_two_len >= seg_one_len
         && (o_phase_two_len == IPT_QUANTA || o_phase_two_len == seg_one_len);
   endproperty
   a_auto_len: assert property (p_auto_len) else $error("auto length wrong");

   property p_tx1_clock;
      second_tx_pin_enable && second_tx_pin_source |-> o_tx1.out == i_can_clk && !o_tx1.oe_n;
   endproperty
   a_tx1_clock: assert property (p_tx1_clock) else $error("tx1 clock not driven");

   property p_tx1_port;
      !second_tx_pin_enable |-> o_tx1.out == i_port_tx1_out && o_tx1.oe_n == i_port_tx1_oe_n;
   endproperty
   a_tx1_port: assert property (p_tx1_port) else $error("tx1 not given to port");

   property p_recessive;
      i_tx_data |-> o_tx0.oe_n == !recessive_drive_high;
   endproperty
   a_recessive: assert property (p_recessive) else $error("recessive drive wrong");

   property p_capture;
      !receive_capture_enable |-> !o_capture_evt;
   endproperty
   a_capture: assert property (p_capture) else $error("capture while disabled");

   property p_err_flag;
      (|i_err_src) |=> flags_q[`CTI_BIT_ERR_FLAG];
   endproperty
   a_err_flag: assert property (p_err_flag) else $error("error flag not set");

   property p_inv_set_wins;
      i_evt.invalid_msg && i_wr && sel_flags |=> flags_q[`CTI_BIT_INV_FLAG];
   endproperty
   a_inv_set_wins: assert property (p_inv_set_wins) else $error("invalid flag lost");

   property p_reserved_read;
      i_rd && sel_three |=> o_rdata[7] == 1'b0 && o_rdata[5:3] == 3'h0;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved bit reads one");

   property p_disabled_gate;
      i_mod_disabled && !(flags_q[`CTI_BIT_WAKE_FLAG] && enables_q[`CTI_BIT_WAKE_FLAG])
         |-> !o_irq_high && !o_irq_low;
   endproperty
   a_disabled_gate: assert property (p_disabled_gate) else $error("irq in disabled mode");

   property p_sticky;
      flags_q[0] && !(i_wr && sel_flags) |=> flags_q[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag cleared by itself");

   property p_quantum_spacing;
      o_quantum_tick && $stable(quantum_prescaler) |=> !o_quantum_tick;
   endproperty
   a_quantum_spacing: assert property (p_quantum_spacing) else $error("quantum ticks too close");

endmodule // cti_top

// ### dv/cti_can_node.sv
// Far-side bus node behind a transceiver, wired with the design's first transmit pin.
`timescale 1ns/1ps
module cti_can_node
   import cti_pkg::*;
(
   input  wire logic     i_dominant,
   input  wire cti_pin_t i_tx0,
   output logic          o_rx
);
   // The transceiver pulls the bus recessive; any party driving low makes it dominant.
   assign o_rx = ~(i_dominant | (~i_tx0.oe_n & ~i_tx0.out));
endmodule // cti_can_node

// ### dv/test_can_timing_io_interrupt_regs.sv
// Self-checking bench for the CAN timing, pin control and event block.
`timescale 1ns/1ps
`include "cti_consts.svh"
module test_can_timing_io_interrupt_regs;
   import cti_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rx_msg = 0, mod_dis = 0, tx_data = 1;
   logic can_clk = 0, ptx_out = 0, ptx_oe_n = 1, dom = 0, rx, cap, wake, tick, irq_h, irq_l;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [3:0]  err = 4'h0, p2len;
   cti_evt_t    evt = '0;
   cti_pin_t    tx0, tx1;
   int          bad_count = 0, check_count = 0;
   logic [11:0] ofs [7] = '{`CTI_OFS_TIMING_ONE, `CTI_OFS_TIMING_TWO, `CTI_OFS_TIMING_THREE,
      `CTI_OFS_PIN_CTRL, `CTI_OFS_FLAGS, `CTI_OFS_ENABLES, `CTI_OFS_PRIORITIES};
   logic [7:0]  msk [7] = '{8'hff, 8'hff, 8'h47, 8'hf0, 8'hff, 8'hff, 8'hff};

   // Clock of 25 ns period.
   always #12.5 clk = ~clk;

   cti_top i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wdata), .o_rdata(rdata), .i_rx_pin(rx), .i_tx_data(tx_data),
      .i_can_clk(can_clk), .i_port_tx1_out(ptx_out), .i_port_tx1_oe_n(ptx_oe_n),
      .i_mod_disabled(mod_dis), .i_rx_msg_evt(rx_msg), .i_evt(evt), .i_err_src(err),
      .o_tx0(tx0), .o_tx1(tx1), .o_capture_evt(cap), .o_wake_evt(wake), .o_quantum_tick(tick),
      .o_phase_two_len(p2len), .o_irq_high(irq_h), .o_irq_low(irq_l));
   cti_can_node i_node (.i_dominant(dom), .i_tx0(tx0), .o_rx(rx));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   // The read data is taken a full cycle after the strobe, where it stands.
   task rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a; rd = 1;
      @(negedge clk);
      rd = 0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task pulse(input cti_evt_t e, input logic [3:0] er);
      @(negedge clk);
      evt = e;
      err = er;
      @(negedge clk);
      evt = '0;
      err = 4'h0;
   endtask
   task set_in(input logic m, input logic t, input logic c);
      @(negedge clk);
      mod_dis = m;
      tx_data = t;
      can_clk = c;
      #5;
   endtask
   // Holds the bus dominant for len cycles and counts wake pulses.
   task bus_act(input int len, output int n);
      n = 0;
      @(negedge clk);
      dom = 1;
      for (int k = 0; k < 20; k++) begin
         @(negedge clk);
         if (k == len - 1) dom = 0;
         n += int'(wake);
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_regs;
      for (int i = 0; i < 7; i++) rd_chk(ofs[i], 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr_reg(ofs[i], 8'hff);
         rd_chk(ofs[i], msk[i]);
         wr_reg(ofs[i], 8'h00);
      end
      wr_reg(12'hf74, 8'hff);
      rd_chk(12'hf74, 8'h00);
   endtask
   task t_phase;
      wr_reg(`CTI_OFS_TIMING_TWO, 8'h80);
      for (int c = 0; c < 8; c++) begin
         wr_reg(`CTI_OFS_TIMING_THREE, 8'(c));
         chk(8'(p2len), 8'(c + 1));
      end
      wr_reg(`CTI_OFS_TIMING_TWO, 8'h00);
      chk(8'(p2len), 8'h02);
      wr_reg(`CTI_OFS_TIMING_TWO, 8'h20);
      chk(8'(p2len), 8'h05);
      wr_reg(`CTI_OFS_TIMING_TWO, 8'h00);
      wr_reg(`CTI_OFS_TIMING_THREE, 8'h00);
   endtask
   task t_pins;
      ptx_out = 1;
      ptx_oe_n = 0;
      set_in(0, 1, 0);
      chk(8'(tx0.oe_n), 8'h01);
      chk(8'(tx1), 8'h02);
      set_in(0, 0, 0);
      chk(8'(tx0), 8'h00);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'h20);
      set_in(0, 1, 0);
      chk(8'(tx0), 8'h02);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'h40);
      chk(8'(tx1.oe_n), 8'h01);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'h60);
      chk(8'(tx1.oe_n), 8'h00);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'hc0);
      set_in(0, 1, 1);
      chk(8'(tx1), 8'h02);
      set_in(0, 1, 0);
      chk(8'(tx1), 8'h00);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'h10);
      rx_msg = 1;
      #5 chk(8'(cap), 8'h01);
      wr_reg(`CTI_OFS_PIN_CTRL, 8'h00);
      chk(8'(cap), 8'h00);
      rx_msg = 0;
   endtask
   task t_flags;
      for (int i = 0; i < 6; i++) begin
         wr_reg(`CTI_OFS_FLAGS, 8'h00);
         pulse(cti_evt_t'(6'(1 << i)), 4'h0);
         rd_chk(`CTI_OFS_FLAGS, (i == 5) ? 8'h80 : 8'(1 << i));
      end
      for (int j = 0; j < 4; j++) begin
         wr_reg(`CTI_OFS_FLAGS, 8'h00);
         pulse('0, 4'(1 << j));
         rd_chk(`CTI_OFS_FLAGS, 8'h20);
      end
      wr_reg(`CTI_OFS_FLAGS, 8'h00);
      // An invalid message in the cycle of a clearing write must still set its flag.
      @(negedge clk);
      addr = `CTI_OFS_FLAGS;
      wdata = 8'h00;
      wr = 1;
      evt.invalid_msg = 1;
      @(negedge clk);
      wr = 0;
      evt = '0;
      rd_chk(`CTI_OFS_FLAGS, 8'h80);
      wr_reg(`CTI_OFS_FLAGS, 8'h00);
   endtask
   task t_irq;
      wr_reg(`CTI_OFS_ENABLES, 8'h01);
      pulse(cti_evt_t'(6'h01), 4'h0);
      chk({irq_h, irq_l}, 8'h01);
      wr_reg(`CTI_OFS_PRIORITIES, 8'h01);
      chk({irq_h, irq_l}, 8'h02);
      wr_reg(`CTI_OFS_ENABLES, 8'h00);
      chk({irq_h, irq_l}, 8'h00);
      wr_reg(`CTI_OFS_ENABLES, 8'h41);
      set_in(1, 1, 0);
      chk({irq_h, irq_l}, 8'h00);
      wr_reg(`CTI_OFS_FLAGS, 8'h41);
      chk({irq_h, irq_l}, 8'h01);
      set_in(0, 1, 0);
      chk({irq_h, irq_l}, 8'h03);
      wr_reg(`CTI_OFS_FLAGS, 8'h00);
      chk({irq_h, irq_l}, 8'h00);
      wr_reg(`CTI_OFS_ENABLES, 8'h00);
      wr_reg(`CTI_OFS_PRIORITIES, 8'h00);
   endtask
   task t_wake;
      int n;
      bus_act(2, n);
      chk(8'(n), 8'h01);
      rd_chk(`CTI_OFS_FLAGS, 8'h40);
      wr_reg(`CTI_OFS_FLAGS, 8'h00);
      wr_reg(`CTI_OFS_TIMING_THREE, 8'h40);
      bus_act(2, n);
      chk(8'(n), 8'h00);
      bus_act(12, n);
      chk(8'(n), 8'h01);
      rd_chk(`CTI_OFS_FLAGS, 8'h40);
      wr_reg(`CTI_OFS_FLAGS, 8'h00);
      wr_reg(`CTI_OFS_TIMING_THREE, 8'h00);
   endtask
   task t_tick;
      int n;
      for (int p = 0; p < 3; p += 2) begin
         wr_reg(`CTI_OFS_TIMING_ONE, 8'(p));
         for (n = 0; n < 300 && tick !== 1'b1; n++) @(negedge clk);
         @(negedge clk);
         for (n = 1; n < 300 && tick !== 1'b1; n++) @(negedge clk);
         chk(8'(n), 8'(2 * p + 2));
      end
      wr_reg(`CTI_OFS_TIMING_ONE, 8'h00);
   endtask

   task test_done;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Main sequence after a 12-cycle reset.
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n = 1;
      t_regs;
      $display("registers done");
      t_phase;
      $display("phase two done");
      t_pins;
      $display("pins done");
      t_flags;
      $display("flags done");
      t_irq;
      $display("interrupts done");
      t_wake;
      $display("wake done");
      t_tick;
      $display("quantum done");
      test_done;
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      #(25 * 20000);
      bad_count++;
      test_done;
   end
endmodule // test_can_timing_io_interrupt_regs
